// ---- srp_pkg.sv ----
// Purpose: Shared constants and types for the system reset and power ports
// Assumes: Byte-wide I/O accesses on the PCI clock
// Notes: Offsets are 16-bit I/O addresses
`default_nettype none
package srp_pkg;
  localparam logic [15:0] ADDR_LEGACY = 16'h0092;
  localparam logic [15:0] ADDR_CMD = 16'h00B2;
  localparam logic [15:0] ADDR_STAT = 16'h00B3;
  localparam logic [15:0] ADDR_RESET = 16'h0CF9;
  localparam logic [15:0] ADDR_RTC_IDX0 = 16'h0070;
  localparam logic [15:0] ADDR_RTC_DAT0 = 16'h0071;
  localparam logic [15:0] RTC_PORT_MASK = 16'hFFF9;
  localparam logic [6:0] CMOS_LOCK_LO = 7'h38;
  localparam logic [6:0] CMOS_LOCK_HI = 7'h3F;
  localparam int BIT_INIT_TRIG = 2;
  localparam int BIT_HARD_SEL = 1;
  localparam int BIT_LOCK = 3;
  localparam int BIT_A20 = 1;
  localparam int BIT_QINIT = 0;
  localparam logic [7:0] RESET_RD_MASK = 8'h02;
  localparam logic [7:0] LEGACY_RD_MASK = 8'h0B;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam int INIT_PULSE_CYC = 16;
  localparam int HARD_RESET_CYC = 16;
  localparam int CLK_NS = 20;
  localparam int CLK_MHZ = 1000 / CLK_NS;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } srp_io_req_t;
  typedef struct packed {
    logic cpu_reset_out;
    logic bus_reset_out_n;
    logic expansion_reset_drive;
  } srp_rst_out_t;
endpackage : srp_pkg
`default_nettype wire

// ---- srp_pulse.sv ----
// Purpose: Fixed-length pulse generator
// Assumes: Start is a one-cycle pulse
// Notes: Retrigger during a pulse restarts the count
`default_nettype none
module srp_pulse #(
  parameter int LEN = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sync_clr,
  input wire logic start,
  output logic active
);
  logic [7:0] cnt_r;
  // R19 counter cleared by reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 8'h00;
    end else if (sync_clr) begin
      cnt_r <= 8'h00;
    end else if (start) begin
      cnt_r <= 8'(LEN);
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign active = (cnt_r != 8'h00);
endmodule : srp_pulse
`default_nettype wire

// ---- srp_top.sv ----
// Purpose: Reset control, legacy control and power command ports
// Assumes: One byte access per request; reads answered in the same cycle
// Notes: Hard reset stretched over a fixed count of clocks
//
// How it works
// R1 - Software writes type, then sets trigger
// R2 - Reset only on trigger rising, bit1 selects
// R3 - Hard reset drives three reset outputs
// R4 - Power good assertion forces hard reset
// R5 - Trigger bit always reads zero
// R6 - Legacy reserved bits read zero
// R7 - Lock blocks clock chip select 38-3F
// R8 - Lock bit sticky until bus reset
// R9 - Address gate follows control bit 1
// R10 - Quick init pulses init sixteen clocks
// R11 - New init only after bit cleared
// R12 - Power ports take byte accesses only
// R13 - Command byte read/write at B2
// R14 - Command write stores, raises interrupt
// R15 - Command reads never raise interrupt
// R16 - Command read stops clock when enabled
// R17 - Status byte read/write at B3
// R18 - Soft reset delivered as init pulse
// R19 - Init counter cleared by reset
`default_nettype none
module srp_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire srp_pkg::srp_io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic io_hit,
  input wire logic power_good_in,
  input wire logic cmd_port_irq_enable,
  input wire logic clock_stop_config,
  input wire logic clock_stop_release,
  input wire logic irq_done,
  input wire logic rtc_cs_req_n,
  output logic clock_chip_select_n,
  output logic sys_mgmt_irq_n,
  output logic cpu_clock_stop_n,
  output logic alt_addr20_out,
  output logic cpu_init_out,
  output srp_pkg::srp_rst_out_t rst_out
);
  logic [7:0] reset_ctl_r;
  logic [7:0] legacy_r;
  logic [7:0] cmd_r;
  logic [7:0] stat_r;
  logic [6:0] rtc_index_r;
  logic pg_d_r;
  logic irq_r;
  logic stop_r;
  logic init_start;
  logic soft_start;
  logic quick_start;
  logic hard_start;
  logic hard_active;
  logic init_active;
  logic wr_reset;
  logic wr_legacy;
  logic wr_cmd;
  logic wr_stat;
  logic rd_cmd;
  logic lock_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_reset = io_req.wr && (io_req.addr == srp_pkg::ADDR_RESET);
  assign wr_legacy = io_req.wr && (io_req.addr == srp_pkg::ADDR_LEGACY);
  // R12 byte ports decode
  assign wr_cmd = io_req.wr && (io_req.addr == srp_pkg::ADDR_CMD);
  assign wr_stat = io_req.wr && (io_req.addr == srp_pkg::ADDR_STAT);
  assign rd_cmd = io_req.rd && (io_req.addr == srp_pkg::ADDR_CMD);

  ////////////////////////////////////////////////////////////////////////////
  // Reset control register
  // R1 two-step write sequence
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reset_ctl_r <= srp_pkg::REG_RESET_VAL;
    end else if (hard_active) begin
      reset_ctl_r <= srp_pkg::REG_RESET_VAL;
    end else if (wr_reset) begin
      reset_ctl_r <= io_req.wdata;
    end
  end

  // R2 trigger rising edge
  assign init_start = wr_reset && io_req.wdata[srp_pkg::BIT_INIT_TRIG]
    && !reset_ctl_r[srp_pkg::BIT_INIT_TRIG];
  assign soft_start = init_start && !io_req.wdata[srp_pkg::BIT_HARD_SEL];

  // R4 power good edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pg_d_r <= 1'b0;
    end else begin
      pg_d_r <= power_good_in;
    end
  end
  assign hard_start = (init_start && io_req.wdata[srp_pkg::BIT_HARD_SEL])
    || (power_good_in && !pg_d_r);

  srp_pulse #(
    .LEN(srp_pkg::HARD_RESET_CYC)
  ) u_hard (
    .mclk(mclk),
    .arst_n(arst_n),
    .sync_clr(1'b0),
    .start(hard_start),
    .active(hard_active)
  );

  // R3 all three resets
  always_comb begin
    rst_out.cpu_reset_out = hard_active;
    rst_out.bus_reset_out_n = !hard_active;
    rst_out.expansion_reset_drive = hard_active;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Legacy control register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      legacy_r <= srp_pkg::REG_RESET_VAL;
    end else if (hard_active) begin
      // R8 cleared by bus reset
      legacy_r <= srp_pkg::REG_RESET_VAL;
    end else if (wr_legacy) begin
      legacy_r[srp_pkg::BIT_A20] <= io_req.wdata[srp_pkg::BIT_A20];
      legacy_r[srp_pkg::BIT_QINIT] <= io_req.wdata[srp_pkg::BIT_QINIT];
      // R8 sticky lock set
      legacy_r[srp_pkg::BIT_LOCK] <= legacy_r[srp_pkg::BIT_LOCK]
        | io_req.wdata[srp_pkg::BIT_LOCK];
    end
  end

  // R9 address gate drive
  assign alt_addr20_out = legacy_r[srp_pkg::BIT_A20];

  // R11 fresh setting only
  assign quick_start = wr_legacy && io_req.wdata[srp_pkg::BIT_QINIT]
    && !legacy_r[srp_pkg::BIT_QINIT];

  // R10 sixteen clock init
  // R18 soft reset init
  srp_pulse #(
    .LEN(srp_pkg::INIT_PULSE_CYC)
  ) u_init (
    .mclk(mclk),
    .arst_n(arst_n),
    .sync_clr(hard_active),
    .start(quick_start || soft_start),
    .active(init_active)
  );
  assign cpu_init_out = init_active;

  ////////////////////////////////////////////////////////////////////////////
  // Clock chip index tracking and lock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rtc_index_r <= 7'h00;
    end else if (io_req.wr
      && ((io_req.addr & srp_pkg::RTC_PORT_MASK) == srp_pkg::ADDR_RTC_IDX0)) begin
      rtc_index_r <= io_req.wdata[6:0];
    end
  end

  // R7 lock suppresses select
  assign lock_hit = legacy_r[srp_pkg::BIT_LOCK]
    && ((io_req.addr & srp_pkg::RTC_PORT_MASK) == srp_pkg::ADDR_RTC_DAT0)
    && (rtc_index_r >= srp_pkg::CMOS_LOCK_LO)
    && (rtc_index_r <= srp_pkg::CMOS_LOCK_HI);
  assign clock_chip_select_n = rtc_cs_req_n || lock_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Power command and status ports
  // R13 command byte storage
  // R14 store every write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_r <= srp_pkg::REG_RESET_VAL;
    end else if (wr_cmd) begin
      cmd_r <= io_req.wdata;
    end
  end

  // R17 status byte storage
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stat_r <= srp_pkg::REG_RESET_VAL;
    end else if (wr_stat) begin
      stat_r <= io_req.wdata;
    end
  end

  // R14 write raises interrupt
  // R15 reads never interrupt
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
    end else if (wr_cmd && cmd_port_irq_enable) begin
      irq_r <= 1'b1;
    end else if (irq_done) begin
      irq_r <= 1'b0;
    end
  end
  assign sys_mgmt_irq_n = !irq_r;

  // R16 read stops clock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stop_r <= 1'b0;
    end else if (rd_cmd && clock_stop_config) begin
      stop_r <= 1'b1;
    end else if (clock_stop_release) begin
      stop_r <= 1'b0;
    end
  end
  assign cpu_clock_stop_n = !stop_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    io_hit = 1'b1;
    io_rdata = 8'h00;
    case (io_req.addr)
      // R5 trigger reads zero
      srp_pkg::ADDR_RESET: io_rdata = reset_ctl_r & srp_pkg::RESET_RD_MASK;
      // R6 reserved reads zero
      srp_pkg::ADDR_LEGACY: io_rdata = legacy_r & srp_pkg::LEGACY_RD_MASK;
      srp_pkg::ADDR_CMD: io_rdata = cmd_r;
      srp_pkg::ADDR_STAT: io_rdata = stat_r;
      default: io_hit = 1'b0;
    endcase
    if (!io_req.rd) begin
      io_rdata = 8'h00;
    end
  end
endmodule : srp_top
`default_nettype wire

// ---- srp_top_checker.sv ----
// Purpose: Port checks for srp_top
// Assumes: One clock domain
// Notes: Bound below
`default_nettype none
module srp_top_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire srp_pkg::srp_io_req_t io_req,
  input wire logic [7:0] io_rdata,
  input wire logic cmd_port_irq_enable,
  input wire logic clock_stop_config,
  input wire logic power_good_in,
  input wire logic sys_mgmt_irq_n,
  input wire logic cpu_clock_stop_n,
  input wire logic alt_addr20_out,
  input wire logic cpu_init_out,
  input wire srp_pkg::srp_rst_out_t rst_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [7:0] init_cnt_r;
  wire logic rd_cmd = io_req.rd && io_req.addr == srp_pkg::ADDR_CMD;
  wire logic wr_leg = io_req.wr && io_req.addr == srp_pkg::ADDR_LEGACY;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) init_cnt_r <= 8'h00;
    else init_cnt_r <= cpu_init_out ? init_cnt_r + 8'h01 : 8'h00;
  end
  trig_reads_zero_a: assert property (
    io_req.rd && io_req.addr == srp_pkg::ADDR_RESET |-> !io_rdata[2]) else $error("trig bit set");
  legacy_rsvd_zero_a: assert property (
    io_req.rd && io_req.addr == srp_pkg::ADDR_LEGACY |-> (io_rdata & 8'hF4) == 8'h00)
    else $error("legacy reserved set");
  addr20_follows_a: assert property (
    wr_leg |=> alt_addr20_out == $past(io_req.wdata[1])) else $error("addr20 wrong");
  irq_on_write_a: assert property (
    io_req.wr && io_req.addr == srp_pkg::ADDR_CMD && cmd_port_irq_enable |=> !sys_mgmt_irq_n)
    else $error("no irq");
  read_no_irq_a: assert property (
    rd_cmd && !io_req.wr && sys_mgmt_irq_n |=> sys_mgmt_irq_n) else $error("irq on read");
  stop_on_read_a: assert property (
    rd_cmd && clock_stop_config |=> !cpu_clock_stop_n) else $error("no clock stop");
  reset_trio_a: assert property (
    $rose(rst_out.cpu_reset_out) |-> (!rst_out.bus_reset_out_n && rst_out.expansion_reset_drive)[*8])
    else $error("reset outputs split");
  power_good_a: assert property (
    $rose(power_good_in) |=> rst_out.cpu_reset_out) else $error("no reset on power good");
  init_length_a: assert property (
    $fell(cpu_init_out) |-> init_cnt_r == 8'h10) else $error("init length wrong");
  cover property ($rose(cpu_init_out));
  cover property ($fell(rst_out.bus_reset_out_n));
  cover property ($fell(cpu_clock_stop_n));
endmodule : srp_top_checker
bind srp_top srp_top_checker i_chk (.mclk, .arst_n, .io_req, .io_rdata, .cmd_port_irq_enable,
  .clock_stop_config, .power_good_in, .sys_mgmt_irq_n, .cpu_clock_stop_n, .alt_addr20_out,
  .cpu_init_out, .rst_out);
`default_nettype wire

// ---- srp_host_model.sv ----
// Purpose: Host core and reset network
// Assumes: Prompt handler
// Notes: Measures init and reset pulses
`default_nettype none
module srp_host_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cpu_init_out,
  input wire srp_pkg::srp_rst_out_t rst_out,
  input wire logic sys_mgmt_irq_n,
  input wire logic cpu_clock_stop_n,
  output logic irq_done,
  output logic clock_stop_release,
  output logic [7:0] n_init,
  output logic [7:0] n_rst,
  output logic [7:0] init_len,
  output logic [7:0] rst_len
);
  logic [7:0] ci_r;
  logic [7:0] cr_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {irq_done, clock_stop_release, n_init, n_rst, init_len, rst_len, ci_r, cr_r} <= '0;
    end else begin
      irq_done <= !sys_mgmt_irq_n;
      clock_stop_release <= !cpu_clock_stop_n;
      ci_r <= cpu_init_out ? ci_r + 8'h01 : 8'h00;
      cr_r <= rst_out.cpu_reset_out ? cr_r + 8'h01 : 8'h00;
      if (!cpu_init_out && ci_r != 8'h00) begin
        n_init <= n_init + 8'h01;
        init_len <= ci_r;
      end
      if (!rst_out.cpu_reset_out && cr_r != 8'h00) begin
        n_rst <= n_rst + 8'h01;
        rst_len <= cr_r;
      end
    end
  end
endmodule : srp_host_model
`default_nettype wire

// ---- system_reset_and_apm_ports_tb.sv ----
// Purpose: Register level test of srp_top
// Assumes: Byte accesses only
// Notes: Host model clears irq and stop
`default_nettype none
module system_reset_and_apm_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] LG = srp_pkg::ADDR_LEGACY, CM = srp_pkg::ADDR_CMD,
    ST = srp_pkg::ADDR_STAT, RS = srp_pkg::ADDR_RESET;
  srp_pkg::srp_io_req_t io_req;
  srp_pkg::srp_rst_out_t rst_out;
  logic [7:0] io_rdata, n_init, n_rst, init_len, rst_len;
  logic mclk, arst_n, pg, hit, done, rel, cs_n, irq_n, stop_n, a20, init, hit_s, cs_s;
  logic irq_en, stop_en, rtc_req_n;
  int n_fail, n_checks, cyc;
  srp_top i_srp_top (.mclk(mclk), .arst_n(arst_n), .io_req(io_req), .io_rdata(io_rdata),
    .io_hit(hit), .power_good_in(pg), .cmd_port_irq_enable(irq_en), .clock_stop_config(stop_en),
    .clock_stop_release(rel), .irq_done(done), .rtc_cs_req_n(rtc_req_n),
    .clock_chip_select_n(cs_n), .sys_mgmt_irq_n(irq_n), .cpu_clock_stop_n(stop_n),
    .alt_addr20_out(a20), .cpu_init_out(init), .rst_out(rst_out));
  srp_host_model i_srp_host_model (.mclk(mclk), .arst_n(arst_n), .cpu_init_out(init),
    .rst_out(rst_out), .sys_mgmt_irq_n(irq_n), .cpu_clock_stop_n(stop_n), .irq_done(done),
    .clock_stop_release(rel), .n_init(n_init), .n_rst(n_rst), .init_len(init_len),
    .rst_len(rst_len));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    io_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    io_req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    io_req <= '{1'b0, 1'b1, a, 8'h00};
    #1;
    chk(io_rdata, e);
    hit_s = hit;
    cs_s = cs_n;
    @(posedge mclk);
    io_req <= '0;
    #1;
  endtask : rd
  task automatic idle();
    repeat (24) @(posedge mclk);
    #1;
  endtask : idle
  task tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    io_req = '0;
    pg = 1'b0;
    irq_en = 1'b1;
    stop_en = 1'b1;
    rtc_req_n = 1'b0;
    arst_n = 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    rd(LG, 8'h00);
    rd(CM, 8'h00);
    rd(ST, 8'h00);
    rd(RS, 8'h00);
    rd(16'h0080, 8'h00);
    chk(hit_s, 1'b0);
    wr(ST, 8'hA5);
    rd(ST, 8'hA5);
    chk(hit_s, 1'b1);
    wr(CM, 8'h5A);
    chk(irq_n, 1'b0);
    rd(CM, 8'h5A);
    chk(irq_n, 1'b1);
    chk(stop_n, 1'b0);
    wr(LG, 8'hF6);
    rd(LG, 8'h02);
    chk(a20, 1'b1);
    wr(LG, 8'h03);
    idle();
    chk(init_len, 8'h10);
    wr(LG, 8'h03);
    idle();
    chk(n_init, 8'h01);
    wr(LG, 8'h02);
    wr(LG, 8'h03);
    idle();
    chk(n_init, 8'h02);
    wr(RS, 8'h00);
    wr(RS, 8'h04);
    idle();
    chk(n_init, 8'h03);
    chk(n_rst, 8'h00);
    wr(RS, 8'h04);
    idle();
    chk(n_init, 8'h03);
    rd(RS, 8'h00);
    wr(LG, 8'h0B);
    wr(16'h0070, 8'h38);
    rd(16'h0071, 8'h00);
    chk(cs_s, 1'b1);
    wr(16'h0070, 8'h30);
    rd(16'h0071, 8'h00);
    chk(cs_s, 1'b0);
    wr(LG, 8'h02);
    rd(LG, 8'h0A);
    wr(RS, 8'h02);
    wr(RS, 8'h06);
    chk(rst_out, 3'h5);
    idle();
    chk(n_rst, 8'h01);
    chk(rst_len, 8'h10);
    chk(rst_out, 3'h2);
    rd(LG, 8'h00);
    @(posedge mclk);
    pg <= 1'b1;
    idle();
    chk(n_rst, 8'h02);
    @(posedge mclk);
    irq_en <= 1'b0;
    stop_en <= 1'b0;
    rtc_req_n <= 1'b1;
    wr(CM, 8'h3C);
    chk(irq_n, 1'b1);
    rd(CM, 8'h3C);
    chk(stop_n, 1'b1);
    rd(16'h0071, 8'h00);
    chk(cs_s, 1'b1);
    tally_and_finish();
  end
endmodule : system_reset_and_apm_ports_tb
`default_nettype wire
